/* tfp_field_model.sv */
// Purpose: Terminal and reference source beside the traverse block
// Assumes: Bench sets the requests; they land on the next rising edge
// Notes: Registered like a real input stage, so one cycle of delay
`timescale 1ns/1ps
`default_nettype none

module tfp_field_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] ref_set,
  input wire logic [7:0] term_set,
  output logic [15:0] freq_ref,
  output logic [7:0] term_in
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_ref <= 16'h0000;
      term_in <= 8'h00;
    end
    else
    begin
      freq_ref <= ref_set;
      // Follows term_set one cycle later, with no check of its function byte
      term_in <= term_set;
    end
  end
endmodule

`default_nettype wire

/* tfp_pkg.sv */
// Purpose: Types shared by the traverse profile block
// Assumes: Constants live in tfp_regs.svh
// Notes: State codes are one-hot
package tfp_pkg;

  typedef enum logic [2:0] {
    TFP_IDLE = 3'b001,
    TFP_RISE = 3'b010,
    TFP_FALL = 3'b100
  } tfp_state_t;

  typedef enum logic [2:0] {
    TFP_APP_NONE = 3'h0,
    TFP_APP_TRAVERSE = 3'h1,
    TFP_APP_PROCESS_LOOP_REGULATION = 3'h2,
    TFP_APP_RESERVED = 3'h3,
    TFP_APP_AUTO_SEQUENCE = 3'h4
  } tfp_app_t;

endpackage

/* tfp_regs.svh */
// Purpose: Register map, reset values and timing counts for the traverse profile block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Percent fields in 0.1 % units, times in 0.1 s units
`ifndef TFP_REGS_SVH
`define TFP_REGS_SVH

`define TFP_ADDR_MODE 12'h000
`define TFP_ADDR_AMPL 12'h004
`define TFP_ADDR_SCRAMBLE 12'h008
`define TFP_ADDR_ACC_TIME 12'h00c
`define TFP_ADDR_DEC_TIME 12'h010
`define TFP_ADDR_UPPER_SHIFT 12'h014
`define TFP_ADDR_LOWER_SHIFT 12'h018
`define TFP_ADDR_TFUNC_LO 12'h01c
`define TFP_ADDR_TFUNC_HI 12'h020
`define TFP_ADDR_STATUS 12'h024
`define TFP_ADDR_FREQ 12'h028

`define TFP_MODE_TRAVERSE 3'h1
`define TFP_FUNC_LOWER_SHIFT 8'h1b
`define TFP_FUNC_UPPER_SHIFT 8'h1c

`define TFP_AMPL_MAX 10'h0c8
`define TFP_SCRAMBLE_MAX 10'h1f4
`define TFP_SHIFT_MAX 10'h0c8
`define TFP_TIME_MIN 13'h0001
`define TFP_TIME_MAX 13'h1770

`define TFP_RST_MODE 3'h0
`define TFP_RST_PCT 10'h000
`define TFP_RST_ACC_TIME 13'h0014
`define TFP_RST_DEC_TIME 13'h001e
`define TFP_RST_TFUNC 32'h0000_0000

`define TFP_PCT_SCALE 26'h00003e8
`define TFP_CLK_PERIOD_NS 100
`define TFP_TIME_STEP_NS 100000000
`define TFP_CYC_PER_STEP (`TFP_TIME_STEP_NS / `TFP_CLK_PERIOD_NS)

`endif

/* tfp_traverse.sv */
// Purpose: Traverse frequency-profile generator with APB register access
// Assumes: freq_ref and term_in synchronous to pclk; frequency in 0.01 Hz units
// Notes: Notes on behaviour follow
`timescale 1ns/1ps
`include "tfp_regs.svh"
`default_nettype none

module tfp_traverse
  import tfp_pkg::*;
#(
  parameter logic [33:0] CYC_PER_STEP = 34'(`TFP_CYC_PER_STEP)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] freq_ref,
  input wire logic [7:0] term_in,
  output logic [15:0] freq_cmd,
  output logic traverse_active
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [9:0] p);
    logic [25:0] prod;
    prod = 26'(base) * 26'(p);
    pct_of = 16'(prod / `TFP_PCT_SCALE);
  endfunction

  function automatic logic [9:0] clamp_pct(input logic [31:0] v, input logic [9:0] lim);
    clamp_pct = (v > 32'(lim)) ? lim : v[9:0];
  endfunction

  function automatic logic [12:0] clamp_time(input logic [31:0] v);
    if (v < 32'(`TFP_TIME_MIN))
      clamp_time = `TFP_TIME_MIN;
    else if (v > 32'(`TFP_TIME_MAX))
      clamp_time = `TFP_TIME_MAX;
    else
      clamp_time = v[12:0];
  endfunction

  function automatic logic [33:0] ramp_cycles(input logic [12:0] t);
    ramp_cycles = 34'(t) * CYC_PER_STEP;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0] app_mode;
  logic [9:0] ampl_pct;
  logic [9:0] scramble_pct;
  logic [12:0] acc_time;
  logic [12:0] dec_time;
  logic [9:0] upper_shift_amount;
  logic [9:0] lower_shift_amount;
  logic [63:0] input_terminal_function;
  tfp_state_t state;
  logic signed [18:0] pos;
  logic [33:0] acc;
  logic upper_on;
  logic lower_on;

  logic access;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_data;

  assign access = psel && penable;
  assign wr_en = access && pwrite && addr_ok;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      app_mode <= `TFP_RST_MODE;
      ampl_pct <= `TFP_RST_PCT;
      scramble_pct <= `TFP_RST_PCT;
      acc_time <= `TFP_RST_ACC_TIME;
      dec_time <= `TFP_RST_DEC_TIME;
      upper_shift_amount <= `TFP_RST_PCT;
      lower_shift_amount <= `TFP_RST_PCT;
      input_terminal_function <= {`TFP_RST_TFUNC, `TFP_RST_TFUNC};
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `TFP_ADDR_MODE: app_mode <= pwdata[2:0];
        `TFP_ADDR_AMPL: ampl_pct <= clamp_pct(pwdata, `TFP_AMPL_MAX);
        `TFP_ADDR_SCRAMBLE: scramble_pct <= clamp_pct(pwdata, `TFP_SCRAMBLE_MAX);
        `TFP_ADDR_ACC_TIME: acc_time <= clamp_time(pwdata);
        `TFP_ADDR_DEC_TIME: dec_time <= clamp_time(pwdata);
        `TFP_ADDR_UPPER_SHIFT: upper_shift_amount <= clamp_pct(pwdata, `TFP_SHIFT_MAX);
        `TFP_ADDR_LOWER_SHIFT: lower_shift_amount <= clamp_pct(pwdata, `TFP_SHIFT_MAX);
        `TFP_ADDR_TFUNC_LO: input_terminal_function[31:0] <= pwdata;
        `TFP_ADDR_TFUNC_HI: input_terminal_function[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr)
      `TFP_ADDR_MODE: rd_data = 32'(app_mode);
      `TFP_ADDR_AMPL: rd_data = 32'(ampl_pct);
      `TFP_ADDR_SCRAMBLE: rd_data = 32'(scramble_pct);
      `TFP_ADDR_ACC_TIME: rd_data = 32'(acc_time);
      `TFP_ADDR_DEC_TIME: rd_data = 32'(dec_time);
      `TFP_ADDR_UPPER_SHIFT: rd_data = 32'(upper_shift_amount);
      `TFP_ADDR_LOWER_SHIFT: rd_data = 32'(lower_shift_amount);
      `TFP_ADDR_TFUNC_LO: rd_data = input_terminal_function[31:0];
      `TFP_ADDR_TFUNC_HI: rd_data = input_terminal_function[63:32];
      `TFP_ADDR_STATUS: rd_data = {27'h0, lower_on, upper_on, state};
      `TFP_ADDR_FREQ: rd_data = 32'(freq_cmd);
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // Terminal decode

  always_comb
  begin
    upper_on = 1'b0;
    lower_on = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      // Unassigned terminals are ignored
      if (term_in[i] && input_terminal_function[8*i +: 8] == `TFP_FUNC_UPPER_SHIFT)
        upper_on = 1'b1;
      if (term_in[i] && input_terminal_function[8*i +: 8] == `TFP_FUNC_LOWER_SHIFT)
        lower_on = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Profile

  logic trav;
  logic [15:0] amp;
  logic [15:0] scr;
  logic [15:0] up_amt;
  logic [15:0] lo_amt;
  logic signed [18:0] amp_s;
  logic signed [18:0] center;
  logic signed [18:0] next_freq;
  logic [33:0] two_a;
  logic [33:0] t_rise;
  logic [33:0] t_fall;

  assign trav = (app_mode == `TFP_MODE_TRAVERSE);
  assign amp = pct_of(freq_ref, ampl_pct);
  assign scr = pct_of(amp, scramble_pct);
  assign up_amt = upper_on ? pct_of(freq_ref, upper_shift_amount) : 16'h0000;
  assign lo_amt = lower_on ? pct_of(freq_ref, lower_shift_amount) : 16'h0000;
  assign amp_s = 19'(amp);
  assign center = 19'(freq_ref) + 19'(up_amt) - 19'(lo_amt);
  assign next_freq = center + pos;
  // Full swing spans twice the amplitude in one ramp time
  assign two_a = {17'h0, amp, 1'b0};
  assign t_rise = ramp_cycles(acc_time);
  assign t_fall = ramp_cycles(dec_time);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= TFP_IDLE;
      pos <= 19'sh0;
      acc <= 34'h0;
    end
    else if (!trav)
    begin
      state <= TFP_IDLE;
      pos <= 19'sh0;
      acc <= 34'h0;
    end
    else
    begin
      unique case (state)
        TFP_IDLE:
        begin
          state <= TFP_RISE;
          pos <= 19'sh0;
          acc <= 34'h0;
        end
        TFP_RISE:
        begin
          if (pos >= amp_s)
          begin
            // Turn at top with the scramble drop
            state <= TFP_FALL;
            pos <= amp_s - 19'(scr);
            acc <= 34'h0;
          end
          else if (acc + two_a >= t_rise)
          begin
            acc <= acc + two_a - t_rise;
            pos <= pos + 19'sh1;
          end
          else
            acc <= acc + two_a;
        end
        TFP_FALL:
        begin
          if (pos <= -amp_s)
          begin
            state <= TFP_RISE;
            pos <= -amp_s;
            acc <= 34'h0;
          end
          else if (acc + two_a >= t_fall)
          begin
            acc <= acc + two_a - t_fall;
            pos <= pos - 19'sh1;
          end
          else
            acc <= acc + two_a;
        end
        default:
        begin
          state <= TFP_IDLE;
          pos <= 19'sh0;
          acc <= 34'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_cmd <= 16'h0000;
      traverse_active <= 1'b0;
    end
    else
    begin
      traverse_active <= trav;
      // Saturate rather than wrap at either end of the range
      if (!trav)
        freq_cmd <= freq_ref;
      else if (next_freq < 19'sh0)
        freq_cmd <= 16'h0000;
      else if (next_freq > 19'sh0ffff)
        freq_cmd <= 16'hffff;
      else
        freq_cmd <= next_freq[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_mode_off;
    @(posedge pclk) disable iff (!presetn)
    !trav |=> (state == TFP_IDLE) && (freq_cmd == $past(freq_ref));
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("Profile active outside traverse");

  property p_amp_pct;
    @(posedge pclk) disable iff (!presetn)
    32'(amp) * 32'd1000 <= 32'(freq_ref) * 32'(ampl_pct);
  endproperty
  a_amp_pct: assert property (p_amp_pct) else $error("Amplitude exceeds setting");

  property p_scramble;
    @(posedge pclk) disable iff (!presetn)
    (trav && state == TFP_RISE && pos >= amp_s)
      |=> (state == TFP_FALL) && (pos == $past(amp_s) - 19'($past(scr)));
  endproperty
  a_scramble: assert property (p_scramble) else $error("Missing scramble jump");

  property p_ramp_acc;
    @(posedge pclk) disable iff (!presetn)
    (state == TFP_RISE && $stable(t_rise) && $stable(two_a)) |-> acc < t_rise + two_a;
  endproperty
  a_ramp_acc: assert property (p_ramp_acc) else $error("Rise accumulator overran");

  property p_upper;
    @(posedge pclk) disable iff (!presetn)
    (upper_on && !lower_on) |-> center == 19'(freq_ref) + 19'(pct_of(freq_ref, upper_shift_amount));
  endproperty
  a_upper: assert property (p_upper) else $error("Upper shift not applied");

  property p_lower;
    @(posedge pclk) disable iff (!presetn)
    (lower_on && !upper_on) |-> center == 19'(freq_ref) - 19'(pct_of(freq_ref, lower_shift_amount));
  endproperty
  a_lower: assert property (p_lower) else $error("Lower shift not applied");

  property p_keep_running;
    @(posedge pclk) disable iff (!presetn)
    (trav && state != TFP_IDLE) ##1 trav |-> state != TFP_IDLE;
  endproperty
  a_keep_running: assert property (p_keep_running) else $error("Traverse stopped");

  property p_bottom_turn;
    @(posedge pclk) disable iff (!presetn)
    (trav && state == TFP_FALL && pos <= -amp_s && amp_s > 19'sh0)
      |=> state == TFP_RISE ##1 (!$past(trav) || state == TFP_RISE);
  endproperty
  a_bottom_turn: assert property (p_bottom_turn) else $error("No turn at bottom");

  property p_unused_term;
    @(posedge pclk) disable iff (!presetn)
    (input_terminal_function == 64'h0) |-> !upper_on && !lower_on;
  endproperty
  a_unused_term: assert property (p_unused_term) else $error("Unassigned terminal acted");

endmodule

`default_nettype wire

/* traverse_frequency_profile_tb.sv */
// Purpose: Self-checking bench for the traverse profile block
// Assumes: Small CYC_PER_STEP keeps ramps short
// Notes: Random reference and terminal codes from a fixed seed
`timescale 1ns/1ps
`include "tfp_regs.svh"
`default_nettype none

module traverse_frequency_profile_tb
  import tfp_pkg::*;
;
  localparam int CYC = 16;
  localparam int REF = 2000;
  localparam int AMP = 100;
  localparam int SCR = 100;
  localparam int ACC = 50;
  localparam int DEC = 100;
  localparam int UP = 50;
  localparam int LO = 25;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] freq_ref;
  logic [7:0] term_in;
  logic [15:0] freq_cmd;
  logic traverse_active;
  logic [15:0] ref_set;
  logic [7:0] term_set;
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] lo_f;
  logic [15:0] hi_f;
  int fail_count;
  int cmp_count;
  int cyc;
  int amp;
  tfp_app_t modes[4] = '{TFP_APP_NONE, TFP_APP_PROCESS_LOOP_REGULATION, TFP_APP_RESERVED,
    TFP_APP_AUTO_SEQUENCE};
  logic [11:0] cl_a[6] = '{`TFP_ADDR_AMPL, `TFP_ADDR_SCRAMBLE, `TFP_ADDR_ACC_TIME,
    `TFP_ADDR_DEC_TIME, `TFP_ADDR_UPPER_SHIFT, `TFP_ADDR_LOWER_SHIFT};
  logic [31:0] cl_w[6] = '{32'h3ff, 32'h3ff, 32'h0, 32'h1fff, 32'h3ff, 32'h3ff};
  logic [31:0] cl_e[6] = '{32'd200, 32'd500, 32'd1, 32'd6000, 32'd200, 32'd200};
  logic [7:0] terms[4] = '{8'h08, 8'h28, 8'h20, 8'hd7};

  tfp_field_model i_field (.pclk(pclk), .presetn(presetn), .ref_set(ref_set),
    .term_set(term_set), .freq_ref(freq_ref), .term_in(term_in));
  tfp_traverse #(.CYC_PER_STEP(34'(CYC))) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .freq_ref(freq_ref),
    .term_in(term_in), .freq_cmd(freq_cmd), .traverse_active(traverse_active));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int pct(input int b, input int p);
    return b * p / 1000;
  endfunction
  // Offsets move the centre; terminals 3 and 5 carry the two functions
  function automatic int ctr(input logic [7:0] t);
    return REF + (t[3] ? pct(REF, UP) : 0) - (t[5] ? pct(REF, LO) : 0);
  endfunction
  function automatic logic [7:0] rnd_fn();
    return 8'($urandom_range(29, 255));
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ramp lengths land within a few cycles of the ideal figure
  task automatic chk_near(input string nm, input int exp, input int got);
    cmp_count++;
    if (got < exp - 8 || got > exp + 8)
    begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk_val(nm, exp, rdat);
  endtask
  task automatic wait_freq(input int v, output int n);
    n = 0;
    while (freq_cmd !== 16'(v) && n < 5000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 5000) fail_count++;
  endtask
  task automatic window(input int n, output logic [15:0] lo, output logic [15:0] hi);
    lo = 16'hffff;
    hi = 16'h0000;
    repeat (n)
    begin
      @(posedge pclk);
      #1;
      if (freq_cmd < lo) lo = freq_cmd;
      if (freq_cmd > hi) hi = freq_cmd;
    end
  endtask
  task automatic results();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // About 25k cycles are needed; the margin covers slow ramps
  initial
  begin
    #(100 * 40000);
    fail_count++;
    results();
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ref_set = 16'h0000;
    term_set = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'haece9cd0));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("mode", `TFP_ADDR_MODE, 32'h0);
    rd_chk("ampl", `TFP_ADDR_AMPL, 32'h0);
    rd_chk("acc", `TFP_ADDR_ACC_TIME, 32'd20);
    rd_chk("dec", `TFP_ADDR_DEC_TIME, 32'd30);
    foreach (cl_a[i])
    begin
      wr(cl_a[i], cl_w[i]);
      rd_chk("clamp", cl_a[i], cl_e[i]);
    end
    apb(1'b0, 12'h0fc, 32'h0, rdat, rerr);
    chk_val("pslverr", 32'h1, 32'(rerr));
    chk_val("pready", 32'h1, 32'(pready));
    wr(`TFP_ADDR_AMPL, 32'(AMP));
    wr(`TFP_ADDR_SCRAMBLE, 32'(SCR));
    wr(`TFP_ADDR_ACC_TIME, 32'(ACC));
    wr(`TFP_ADDR_DEC_TIME, 32'(DEC));
    wr(`TFP_ADDR_UPPER_SHIFT, 32'(UP));
    wr(`TFP_ADDR_LOWER_SHIFT, 32'(LO));
    wr(`TFP_ADDR_TFUNC_LO, {8'h1c, rnd_fn(), rnd_fn(), rnd_fn()});
    wr(`TFP_ADDR_TFUNC_HI, {rnd_fn(), rnd_fn(), 8'h1b, rnd_fn()});
    foreach (modes[i])
    begin
      wr(`TFP_ADDR_MODE, 32'(modes[i]));
      @(posedge pclk);
      ref_set <= 16'($urandom_range(100, 60000));
      repeat (4) @(posedge pclk);
      #1;
      chk_val("freq_cmd", 32'(ref_set), 32'(freq_cmd));
      chk_val("traverse_active", 32'h0, 32'(traverse_active));
    end
    // Idle state code with both shift terminals released
    rd_chk("status", `TFP_ADDR_STATUS, 32'h1);
    rd_chk("freq", `TFP_ADDR_FREQ, 32'(ref_set));
    @(posedge pclk);
    ref_set <= 16'(REF);
    wr(`TFP_ADDR_MODE, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk_val("traverse_active", 32'h1, 32'(traverse_active));
    amp = pct(REF, AMP);
    wait_freq(REF - amp, cyc);
    wait_freq(REF + amp, cyc);
    chk_near("rise", ACC * CYC, cyc);
    repeat (10) if (freq_cmd === 16'(REF + amp))
    begin
      @(posedge pclk);
      #1;
    end
    chk_val("jump", 32'(REF + amp - pct(amp, SCR)), 32'(freq_cmd));
    wait_freq(REF - amp, cyc);
    chk_near("fall", DEC * CYC * (2 * amp - pct(amp, SCR)) / (2 * amp), cyc);
    // First window lets the centre settle after a terminal change
    foreach (terms[i])
    begin
      @(posedge pclk);
      term_set <= terms[i];
      window(2600, lo_f, hi_f);
      window(2600, lo_f, hi_f);
      chk_val("max", 32'(ctr(terms[i]) + amp), 32'(hi_f));
      chk_val("min", 32'(ctr(terms[i]) - amp), 32'(lo_f));
    end
    results();
  end
endmodule

`default_nettype wire
